// ==== omcs_pkg.sv ====
package omcs_pkg;
  localparam int CLK_MHZ = 250;
  // Fault clear hold time, least
  localparam int T_RESET_NS = 10000;
  localparam int RESET_CYC = (T_RESET_NS * CLK_MHZ + 999) / 1000;
  // Power-on initialization, longest
  localparam int T_INIT_MS = 300;
  localparam int INIT_CYC_DEF = T_INIT_MS * CLK_MHZ * 1000;
  // Bus free time, least
  localparam int T_BUF_NS = 20000;
  localparam int BUF_CYC_DEF = (T_BUF_NS * CLK_MHZ + 999) / 1000;
  // Write cycle time the host waits out
  localparam int T_WRITE_MS = 40;
  localparam int WRITE_CYC_DEF = T_WRITE_MS * CLK_MHZ * 1000;
  // Serial clock rate, highest
  localparam int F_SCL_KHZ = 400;
  localparam int SCL_HALF_CYC = (CLK_MHZ * 1000 + 2 * F_SCL_KHZ - 1) / (2 * F_SCL_KHZ);
  // Clock stretch, longest
  localparam int T_STRETCH_US = 500;
  localparam int STRETCH_MAX_CYC = T_STRETCH_US * CLK_MHZ;
  localparam int STRETCH_CYC_DEF = 32;

  localparam logic [6:0] ID_ADDR = 7'h50;
  localparam logic [6:0] DIAG_ADDR = 7'h51;
  localparam logic [7:0] REG_CTRL_STAT = 8'h6e;
  localparam logic [7:0] REG_TX_EQ = 8'h72;
  localparam logic [7:0] REG_RX_EMPH = 8'h73;
  localparam int CS_HW_DIS = 7;
  localparam int CS_SOFT_DIS = 6;
  localparam int CS_FAULT = 2;
  localparam int CS_LOS = 1;
  localparam int CS_NOT_READY = 0;
  localparam logic [3:0] EQ_MAX = 4'ha;
  localparam logic [3:0] CODE_RESET = 4'h0;

  localparam logic [7:0] APB_CTRL = 8'h00;
  localparam logic [7:0] APB_CMD = 8'h04;
  localparam logic [7:0] APB_STAT = 8'h08;
  localparam int CTRL_DIS = 0;
  localparam int CTRL_CLR = 1;
  localparam int CMD_OFS_LSB = 0;
  localparam int CMD_DATA_LSB = 8;
  localparam int CMD_READ = 16;
  localparam int CMD_ID = 17;
  localparam int STAT_BUSY = 0;
  localparam int STAT_NACK = 1;
  localparam int STAT_FAULT = 2;
  localparam int STAT_LOS = 3;
  localparam int STAT_DIS = 4;
  localparam int STAT_RD_LSB = 8;
endpackage

// ==== omcs_if.sv ====
interface omcs_if;
  logic tx_dis;
  logic tx_fault;
  logic rx_los;
  logic scl_h_oe;
  logic scl_d_oe;
  logic sda_h_oe;
  logic sda_d_oe;
  wire scl;
  wire sda;
  // Open-drain lines pulled high when nobody drives
  assign scl = ~(scl_h_oe | scl_d_oe);
  assign sda = ~(sda_h_oe | sda_d_oe);
  modport device (
    input tx_dis,
    input scl,
    input sda,
    output tx_fault,
    output rx_los,
    output scl_d_oe,
    output sda_d_oe
  );
  modport host (
    output tx_dis,
    output scl_h_oe,
    output sda_h_oe,
    input scl,
    input sda,
    input tx_fault,
    input rx_los
  );
endinterface

// ==== omcs_host.sv ====
// Our own choice: the APB slave port.
module omcs_host import omcs_pkg::*; #(
  parameter int BUF_CYC = BUF_CYC_DEF,
  parameter int WRITE_CYC = WRITE_CYC_DEF,
  parameter int HALF_CYC = SCL_HALF_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  omcs_if.host link
);
  typedef enum logic [4:0] {
    M_IDLE = 5'b00001, M_GAP = 5'b00010, M_START = 5'b00100, M_BIT = 5'b01000, M_STOP = 5'b10000
  } omcs_mst_type;
  localparam logic [23:0] HALF = 24'(HALF_CYC);
  localparam logic [23:0] HALF_Q = 24'(HALF_CYC / 2);

  omcs_mst_type st_r;
  logic [3:0] s1_r, s2_r;
  logic ctrl_dis_r, rd_op_r, id_op_r, nack_r, gap_start_r;
  logic [11:0] clr_cnt_r;
  logic [7:0] ofs_r, wdat_r, rdata_r, rx_r;
  logic [23:0] cnt_r;
  logic [1:0] sp_r, idx_r;
  logic [3:0] bitn_r;
  logic [8:0] sh_r;
  logic scl_s, sda_s, acc, wr_go, ofs_ok;

  assign scl_s = s2_r[3];
  assign sda_s = s2_r[2];
  assign acc = psel & penable & pready;
  assign ofs_ok = paddr[7:0] == APB_CTRL || paddr[7:0] == APB_CMD || paddr[7:0] == APB_STAT;
  assign wr_go = acc & pwrite & paddr[7:0] == APB_CMD & st_r == M_IDLE;

  function automatic logic [7:0] byte_at(input logic [1:0] i);
    logic [6:0] dev;
    dev = id_op_r ? ID_ADDR : DIAG_ADDR;
    case (i)
      2'd0: byte_at = {dev, 1'b0};
      2'd1: byte_at = ofs_r;
      2'd2: byte_at = rd_op_r ? {dev, 1'b1} : wdat_r;
      default: byte_at = 8'hff;
    endcase
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= 4'h0;
      s2_r <= 4'h0;
    end else begin
      s1_r <= {link.scl, link.sda, link.tx_fault, link.rx_los};
      s2_r <= s1_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~ofs_ok;
      prdata <= 32'h0000_0000;
      if (psel & ~penable & paddr[7:0] == APB_CTRL)
        prdata[CTRL_DIS] <= ctrl_dis_r;
      if (psel & ~penable & paddr[7:0] == APB_STAT) begin
        prdata[STAT_BUSY] <= st_r != M_IDLE;
        prdata[STAT_NACK] <= nack_r;
        prdata[STAT_FAULT] <= s2_r[1];
        prdata[STAT_LOS] <= s2_r[0];
        prdata[STAT_DIS] <= link.tx_dis;
        prdata[STAT_RD_LSB +: 8] <= rdata_r;
      end
    end
  end

  // Laser-off pin and timed fault clear pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_dis_r <= 1'b0;
      clr_cnt_r <= 12'h000;
      link.tx_dis <= 1'b0;
    end else begin
      if (acc & pwrite & paddr[7:0] == APB_CTRL)
        ctrl_dis_r <= pwdata[CTRL_DIS];
      if (acc & pwrite & paddr[7:0] == APB_CTRL & pwdata[CTRL_CLR])
        clr_cnt_r <= 12'(RESET_CYC);
      else if (clr_cnt_r != 12'h000)
        clr_cnt_r <= clr_cnt_r - 12'h001;
      link.tx_dis <= ctrl_dis_r | clr_cnt_r != 12'h000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_op_r <= 1'b0;
      id_op_r <= 1'b0;
      ofs_r <= 8'h00;
      wdat_r <= 8'h00;
    end else if (wr_go) begin
      rd_op_r <= pwdata[CMD_READ];
      id_op_r <= pwdata[CMD_ID];
      ofs_r <= pwdata[CMD_OFS_LSB +: 8];
      wdat_r <= pwdata[CMD_DATA_LSB +: 8];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= M_IDLE;
      cnt_r <= 24'h00_0000;
      sp_r <= 2'd0;
      idx_r <= 2'd0;
      bitn_r <= 4'h0;
      sh_r <= 9'h1ff;
      rx_r <= 8'h00;
      rdata_r <= 8'h00;
      nack_r <= 1'b0;
      gap_start_r <= 1'b0;
      link.scl_h_oe <= 1'b0;
      link.sda_h_oe <= 1'b0;
    end else begin
      if (cnt_r != 24'h00_0000)
        cnt_r <= cnt_r - 24'h00_0001;
      case (st_r)
        M_IDLE: if (wr_go) begin
          nack_r <= 1'b0;
          idx_r <= 2'd0;
          gap_start_r <= 1'b1;
          cnt_r <= 24'(BUF_CYC);
          st_r <= M_GAP;
        end
        M_GAP: if (cnt_r == 24'h00_0000) begin
          st_r <= gap_start_r ? M_START : M_IDLE;
          sp_r <= 2'd0;
          cnt_r <= HALF;
        end
        M_START: case (sp_r)
          2'd0: begin
            link.sda_h_oe <= 1'b0;
            if (cnt_r == 24'h00_0000) begin
              link.scl_h_oe <= 1'b0;
              sp_r <= 2'd1;
              cnt_r <= HALF;
            end
          end
          2'd1: if (!scl_s) begin
            cnt_r <= HALF;
          end else if (cnt_r == 24'h00_0000) begin
            link.sda_h_oe <= 1'b1;
            sp_r <= 2'd2;
            cnt_r <= HALF;
          end
          default: if (cnt_r == 24'h00_0000) begin
            link.scl_h_oe <= 1'b1;
            st_r <= M_BIT;
            sp_r <= 2'd0;
            bitn_r <= 4'h0;
            sh_r <= {byte_at(idx_r), 1'b1};
            cnt_r <= HALF;
          end
        endcase
        M_BIT: if (sp_r == 2'd0) begin
          // Data moves mid low phase, away from clock edges
          if (cnt_r == HALF_Q)
            link.sda_h_oe <= ~sh_r[8];
          if (cnt_r == 24'h00_0000) begin
            link.scl_h_oe <= 1'b0;
            sp_r <= 2'd1;
            cnt_r <= HALF;
          end
        end else if (!scl_s) begin
          cnt_r <= HALF;
        end else if (cnt_r == 24'h00_0000) begin
          link.scl_h_oe <= 1'b1;
          cnt_r <= HALF;
          sp_r <= 2'd0;
          if (bitn_r != 4'h8) begin
            rx_r <= {rx_r[6:0], sda_s};
            bitn_r <= bitn_r + 4'h1;
            sh_r <= {sh_r[7:0], 1'b1};
          end else begin
            bitn_r <= 4'h0;
            sh_r <= {byte_at(idx_r + 2'd1), 1'b1};
            idx_r <= idx_r + 2'd1;
            if (idx_r != 2'd3 && sda_s) begin
              nack_r <= 1'b1;
              st_r <= M_STOP;
            end else if (idx_r == 2'd3 || (idx_r == 2'd2 && !rd_op_r)) begin
              if (idx_r == 2'd3)
                rdata_r <= rx_r;
              st_r <= M_STOP;
            end else if (idx_r == 2'd1 && rd_op_r) begin
              gap_start_r <= 1'b1;
              cnt_r <= 24'(BUF_CYC);
              st_r <= M_GAP;
            end
          end
        end
        M_STOP: if (sp_r == 2'd0) begin
          if (cnt_r == HALF_Q)
            link.sda_h_oe <= 1'b1;
          if (cnt_r == 24'h00_0000) begin
            link.scl_h_oe <= 1'b0;
            sp_r <= 2'd1;
            cnt_r <= HALF;
          end
        end else if (!scl_s) begin
          cnt_r <= HALF;
        end else if (cnt_r == 24'h00_0000) begin
          link.sda_h_oe <= 1'b0;
          gap_start_r <= 1'b0;
          cnt_r <= (!rd_op_r && !nack_r) ? 24'(WRITE_CYC) : 24'(BUF_CYC);
          st_r <= M_GAP;
        end
        default: st_r <= M_IDLE;
      endcase
    end
  end
endmodule

// ==== omcs_device.sv ====
// Summary of operation
// - Laser-off pin kills optical output quickly
// - Laser-off release restores output within 2 ms
// - Initialization clears fault indication within 300 ms
// - Fault pin asserts within 1 ms
// - Laser-off held 10 us clears fault
// - Signal-lost pin asserts within 100 us
// - Signal-lost pin clears within 100 us
// - Soft laser-off bit disables output
// - Clearing soft laser-off bit restores output
// - Soft fault status bit follows fault
// - Soft signal-lost bit follows optical signal
// - Data-not-ready bit high until ready
// - Serial bus ready within 300 ms
// - Host leaves 20 us bus free time
// - Writes complete within 40/80 ms
// - Clock stretch at most 500 us
// - Host clocks at most 400 kHz
// - Equalization code byte, reserved codes refused
// - Emphasis code byte, four bits
module omcs_device import omcs_pkg::*; #(
  parameter int INIT_CYC = INIT_CYC_DEF,
  parameter int STRETCH_CYC = STRETCH_CYC_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  omcs_if.device link,
  input wire logic laser_fault_in,
  input wire logic optical_signal_in,
  output logic laser_on,
  output logic [3:0] tx_eq,
  output logic [3:0] rx_emph
);
  typedef enum logic [5:0] {
    SL_IDLE = 6'b000001, SL_ADDR = 6'b000010, SL_WR = 6'b000100,
    SL_ACK = 6'b001000, SL_RD = 6'b010000, SL_RACK = 6'b100000
  } omcs_slave_type;

  omcs_slave_type st_r;
  logic [4:0] s1_r, s2_r, p_r;
  logic [31:0] init_cnt_r;
  logic init_done_r;
  logic [11:0] dis_cnt_r;
  logic fault_r, soft_dis_r;
  logic [3:0] bitc_r;
  logic [7:0] sh_r, ptr_r;
  logic rd_r, diag_r, first_r, nack_r;
  logic [16:0] str_cnt_r;
  logic hw_dis, fault_s, sig_s, scl_s, sda_s, scl_p, sda_p;
  logic start_ev, stop_ev, rise, fall, byte_end, wr_ev, fault_clr;
  logic [7:0] rd_byte;

  assign hw_dis = s2_r[4];
  assign fault_s = s2_r[3];
  assign sig_s = s2_r[2];
  assign scl_s = s2_r[1];
  assign sda_s = s2_r[0];
  assign scl_p = p_r[1];
  assign sda_p = p_r[0];
  assign start_ev = scl_s & scl_p & sda_p & ~sda_s;
  assign stop_ev = scl_s & scl_p & ~sda_p & sda_s;
  assign rise = scl_s & ~scl_p;
  assign fall = ~scl_s & scl_p;
  assign byte_end = fall & bitc_r == 4'h8 & (st_r == SL_ADDR || st_r == SL_WR);
  assign wr_ev = byte_end & st_r == SL_WR & ~first_r & diag_r;

  function automatic logic [7:0] reg_read(input logic [7:0] ofs, input logic dsel);
    reg_read = 8'h00;
    if (dsel) begin
      case (ofs)
        REG_CTRL_STAT: begin
          reg_read[CS_HW_DIS] = hw_dis;
          reg_read[CS_SOFT_DIS] = soft_dis_r;
          reg_read[CS_FAULT] = fault_r;
          reg_read[CS_LOS] = ~sig_s;
          reg_read[CS_NOT_READY] = ~init_done_r;
        end
        REG_TX_EQ: reg_read = {4'h0, tx_eq};
        REG_RX_EMPH: reg_read = {4'h0, rx_emph};
        default: reg_read = 8'h00;
      endcase
    end
  endfunction

  assign rd_byte = reg_read(ptr_r, diag_r);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Idle pin levels, so no false laser-off edge follows reset
      s1_r <= 5'h07;
      s2_r <= 5'h07;
      p_r <= 5'h07;
    end else begin
      s1_r <= {link.tx_dis, laser_fault_in, optical_signal_in, link.scl, link.sda};
      s2_r <= s1_r;
      p_r <= s2_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_cnt_r <= 32'h0000_0000;
      init_done_r <= 1'b0;
    end else if (!init_done_r) begin
      init_cnt_r <= init_cnt_r + 32'h0000_0001;
      init_done_r <= init_cnt_r >= 32'(INIT_CYC - 1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      dis_cnt_r <= 12'h000;
    else if (!hw_dis)
      dis_cnt_r <= 12'h000;
    else if (dis_cnt_r < 12'(RESET_CYC))
      dis_cnt_r <= dis_cnt_r + 12'h001;
  end

  assign fault_clr = ~hw_dis & p_r[4] & dis_cnt_r >= 12'(RESET_CYC);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      fault_r <= 1'b0;
    else if (fault_s & init_done_r)
      fault_r <= 1'b1;
    else if (fault_clr)
      fault_r <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      laser_on <= 1'b0;
      link.tx_fault <= 1'b1;
      link.rx_los <= 1'b1;
    end else begin
      laser_on <= init_done_r & ~hw_dis & ~soft_dis_r & ~fault_r;
      link.tx_fault <= fault_r | ~init_done_r;
      link.rx_los <= ~sig_s;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_dis_r <= 1'b0;
      tx_eq <= CODE_RESET;
      rx_emph <= CODE_RESET;
    end else if (wr_ev) begin
      case (ptr_r)
        REG_CTRL_STAT: soft_dis_r <= sh_r[CS_SOFT_DIS];
        REG_TX_EQ: if (sh_r[3:0] <= EQ_MAX) tx_eq <= sh_r[3:0];
        REG_RX_EMPH: rx_emph <= sh_r[3:0];
        default: soft_dis_r <= soft_dis_r;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      str_cnt_r <= 17'h0_0000;
      link.scl_d_oe <= 1'b0;
    end else if (byte_end) begin
      str_cnt_r <= 17'(STRETCH_CYC);
      link.scl_d_oe <= 1'b1;
    end else begin
      if (str_cnt_r != 17'h0_0000)
        str_cnt_r <= str_cnt_r - 17'h0_0001;
      link.scl_d_oe <= str_cnt_r > 17'h0_0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= SL_IDLE;
      bitc_r <= 4'h0;
      sh_r <= 8'h00;
      ptr_r <= 8'h00;
      rd_r <= 1'b0;
      diag_r <= 1'b0;
      first_r <= 1'b1;
      nack_r <= 1'b0;
      link.sda_d_oe <= 1'b0;
    end else if (stop_ev || !init_done_r) begin
      st_r <= SL_IDLE;
      link.sda_d_oe <= 1'b0;
    end else if (start_ev) begin
      st_r <= SL_ADDR;
      bitc_r <= 4'h0;
      first_r <= 1'b1;
      link.sda_d_oe <= 1'b0;
    end else begin
      case (st_r)
        SL_ADDR, SL_WR: if (rise) begin
          sh_r <= {sh_r[6:0], sda_s};
          bitc_r <= bitc_r + 4'h1;
        end else if (byte_end) begin
          if (st_r == SL_WR) begin
            link.sda_d_oe <= 1'b1;
            st_r <= SL_ACK;
            first_r <= 1'b0;
            ptr_r <= first_r ? sh_r : ptr_r + 8'h01;
          end else if (sh_r[7:1] == ID_ADDR || sh_r[7:1] == DIAG_ADDR) begin
            link.sda_d_oe <= 1'b1;
            rd_r <= sh_r[0];
            diag_r <= sh_r[7:1] == DIAG_ADDR;
            st_r <= SL_ACK;
          end else begin
            st_r <= SL_IDLE;
          end
        end
        SL_ACK: if (fall) begin
          bitc_r <= 4'h0;
          if (rd_r) begin
            sh_r <= rd_byte;
            link.sda_d_oe <= ~rd_byte[7];
            ptr_r <= ptr_r + 8'h01;
            st_r <= SL_RD;
          end else begin
            link.sda_d_oe <= 1'b0;
            st_r <= SL_WR;
          end
        end
        SL_RD: if (fall) begin
          bitc_r <= bitc_r + 4'h1;
          if (bitc_r == 4'h7) begin
            link.sda_d_oe <= 1'b0;
            st_r <= SL_RACK;
          end else begin
            link.sda_d_oe <= ~sh_r[6];
            sh_r <= {sh_r[6:0], 1'b0};
          end
        end
        SL_RACK: if (rise) begin
          nack_r <= sda_s;
        end else if (fall) begin
          bitc_r <= 4'h0;
          if (nack_r) begin
            st_r <= SL_IDLE;
          end else begin
            sh_r <= rd_byte;
            link.sda_d_oe <= ~rd_byte[7];
            ptr_r <= ptr_r + 8'h01;
            st_r <= SL_RD;
          end
        end
        default: link.sda_d_oe <= 1'b0;
      endcase
    end
  end
endmodule

// ==== omcs_asserts.sv ====
module omcs_asserts import omcs_pkg::*; #(
  parameter int INIT_CYC = INIT_CYC_DEF,
  parameter int STRETCH_CYC = STRETCH_CYC_DEF,
  parameter int BUF_CYC = BUF_CYC_DEF,
  parameter int HALF_CYC = SCL_HALF_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tx_dis,
  input wire logic tx_fault,
  input wire logic rx_los,
  input wire logic scl_h_oe,
  input wire logic scl_d_oe,
  input wire logic sda_h_oe,
  input wire logic sda_d_oe,
  input wire logic scl,
  input wire logic sda
);
  int init_cnt;
  int hold_cnt;
  int str_cnt;
  int stop_cnt;
  int dis_cnt;
  int dis_len_r;
  int since_fall;
  logic idle_r;
  logic scl_q;
  logic sda_q;
  logic start;
  logic stop;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  assign start = scl && scl_q && sda_q && !sda;
  assign stop = scl && scl_q && !sda_q && sda;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_cnt <= 0;
    end else if (init_cnt < INIT_CYC + 100) begin
      init_cnt <= init_cnt + 1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_cnt <= 0;
      str_cnt <= 0;
    end else begin
      hold_cnt <= $changed(scl_h_oe) ? 0 : (hold_cnt < 1000 ? hold_cnt + 1 : hold_cnt);
      str_cnt <= scl_d_oe ? str_cnt + 1 : 0;
    end
  end
  // Bus line history for start and stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      idle_r <= 1'b1;
      stop_cnt <= BUF_CYC;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      idle_r <= stop ? 1'b1 : (start ? 1'b0 : idle_r);
      stop_cnt <= stop ? 0 : (stop_cnt < BUF_CYC ? stop_cnt + 1 : stop_cnt);
    end
  end
  // Length of the last laser-off pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dis_cnt <= 0;
      dis_len_r <= 0;
      since_fall <= 255;
    end else begin
      dis_cnt <= tx_dis ? (dis_cnt < 100000 ? dis_cnt + 1 : dis_cnt) : 0;
      dis_len_r <= $fell(tx_dis) ? dis_cnt : dis_len_r;
      since_fall <= $fell(tx_dis) ? 0 : (since_fall < 255 ? since_fall + 1 : since_fall);
    end
  end
  a_stretch_max: assert property (str_cnt <= STRETCH_CYC + 2)
    else $error("serial clock held low too long");
  a_sda_moves_low: assert property ($changed(sda_d_oe) |-> !scl)
    else $error("device moved data line while clock high");
  a_scl_half_min: assert property ($changed(scl_h_oe) |-> hold_cnt >= HALF_CYC / 2)
    else $error("serial clock phase too short");
  a_bus_free_time: assert property (start && idle_r |-> stop_cnt >= BUF_CYC)
    else $error("start too soon after stop");
  a_init_fault_held: assert property (init_cnt < INIT_CYC - 4 |-> tx_fault)
    else $error("fault pin dropped during initialization");
  a_init_bus_quiet: assert property (init_cnt < INIT_CYC - 4 |-> !sda_d_oe && !scl_d_oe)
    else $error("device drove bus during initialization");
  a_fault_clear_qual: assert property ($fell(tx_fault) |->
    (init_cnt >= INIT_CYC - 4 && init_cnt <= INIT_CYC + 8) ||
    (dis_len_r >= RESET_CYC - 2 && since_fall < 16))
    else $error("fault cleared without qualifying pulse");
  a_host_waits: assert property (scl_d_oe && !scl_h_oe |-> $stable(sda_h_oe))
    else $error("host moved data line during stretch");
  c_start: cover property (start);
  c_stretch: cover property (str_cnt == STRETCH_CYC);
  c_clear: cover property ($fell(tx_fault) && since_fall < 16);
  c_los: cover property ($rose(rx_los));
endmodule

// ==== optical_module_ctrl_status_test.sv ====
module optical_module_ctrl_status_test import omcs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int INIT_N = 2000;
  localparam int STR_N = 40;
  localparam int BUF_N = 50;
  localparam int WR_N = 100;
  localparam int HALF_N = 20;
  typedef struct {logic [31:0] mask; logic [31:0] val; logic err;} omcs_note_type;
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata;
  logic pready, pslverr, laser_on;
  logic laser_fault_in = 0, optical_signal_in = 1;
  logic [3:0] tx_eq, rx_emph;
  int fail_count = 0, checked = 0, cycles = 0, seed = 32565;
  omcs_note_type exp_q[$];
  omcs_if link ();
  omcs_host #(.BUF_CYC(BUF_N), .WRITE_CYC(WR_N), .HALF_CYC(HALF_N)) omcs_host_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link(link));
  omcs_device #(.INIT_CYC(INIT_N), .STRETCH_CYC(STR_N)) omcs_device_inst (
    .pclk(pclk), .presetn(presetn), .link(link), .laser_fault_in(laser_fault_in),
    .optical_signal_in(optical_signal_in), .laser_on(laser_on), .tx_eq(tx_eq),
    .rx_emph(rx_emph));
  omcs_asserts #(.INIT_CYC(INIT_N), .STRETCH_CYC(STR_N), .BUF_CYC(BUF_N), .HALF_CYC(HALF_N))
  omcs_asserts_inst (.pclk(pclk), .presetn(presetn), .tx_dis(link.tx_dis),
    .tx_fault(link.tx_fault), .rx_los(link.rx_los), .scl_h_oe(link.scl_h_oe),
    .scl_d_oe(link.scl_d_oe), .sda_h_oe(link.sda_h_oe), .sda_d_oe(link.sda_d_oe),
    .scl(link.scl), .sda(link.sda));
  initial begin
    forever #2 pclk = ~pclk;
  end
  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 100000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  task automatic cmp_rd(omcs_note_type n, logic [31:0] got, logic err);
    checked++;
    if (((got & n.mask) !== n.val) || (err !== n.err)) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h/%h exp %h/%h", $time, got, err, n.val, n.err);
    end
  endtask
  task automatic cmp_pin(logic [3:0] got, logic [3:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Read results checked against the oldest note
  always @(posedge pclk) begin
    if ((psel & penable & pready & ~pwrite) === 1'b1 && exp_q.size() > 0) begin
      cmp_rd(exp_q.pop_front(), prdata, pslverr);
    end
  end
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d, logic [31:0] m,
                     logic [31:0] v, logic e, output logic [31:0] rd);
    omcs_note_type n;
    n.mask = m;
    n.val = v;
    n.err = e;
    @(posedge pclk);
    if (!wr) exp_q.push_back(n);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= 32'(a);
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_idle();
    logic [31:0] s;
    do apb(0, APB_STAT, 0, 0, 0, 0, s); while (s[STAT_BUSY] !== 1'b0);
  endtask
  task automatic dev_wr(logic [7:0] ofs, logic [7:0] d);
    logic [31:0] s;
    apb(1, APB_CMD, (32'(d) << CMD_DATA_LSB) | 32'(ofs), 0, 0, 0, s);
    wait_idle();
  endtask
  task automatic dev_rd(logic [7:0] ofs, logic [7:0] bm, logic [7:0] bv, logic nk);
    logic [31:0] s;
    apb(1, APB_CMD, (32'h0000_0001 << CMD_READ) | 32'(ofs), 0, 0, 0, s);
    wait_idle();
    apb(0, APB_STAT, 0, {16'h0000, bm, 8'h02}, {16'h0000, bv, 6'h00, nk, 1'b0}, 0, s);
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge pclk);
  endtask
  initial begin
    logic [31:0] s;
    logic [3:0] code;
    logic [3:0] eq;
    tick(2);
    presetn <= 1'b1;
    tick(2);
    apb(0, APB_STAT, 0, 32'h0000_0004, 32'h0000_0004, 0, s);
    dev_rd(REG_CTRL_STAT, 8'h00, 8'h00, 1'b1);
    tick(INIT_N);
    apb(0, APB_STAT, 0, 32'h0000_0004, 32'h0000_0000, 0, s);
    dev_rd(REG_CTRL_STAT, 8'hc7, 8'h00, 1'b0);
    apb(1, APB_CMD, (32'h0000_0003 << CMD_READ) | 32'(REG_CTRL_STAT), 0, 0, 0, s);
    wait_idle();
    apb(0, APB_STAT, 0, 32'h0000_ff02, 32'h0000_0000, 0, s);
    apb(0, 8'h0c, 0, 32'hffff_ffff, 0, 1'b1, s);
    $display("test init done");
    eq = CODE_RESET;
    for (int i = 0; i < 16; i++) begin
      dev_wr(REG_TX_EQ, 8'(i));
      if (i <= int'(EQ_MAX)) eq = 4'(i);
      cmp_pin(tx_eq, eq);
    end
    dev_rd(REG_TX_EQ, 8'hff, {4'h0, eq}, 1'b0);
    for (int i = 0; i < 4; i++) begin
      code = {i[0], 3'($random(seed))};
      dev_wr(REG_RX_EMPH, {4'h0, code});
      cmp_pin(rx_emph, code);
    end
    dev_rd(REG_RX_EMPH, 8'hff, {4'h0, code}, 1'b0);
    $display("test codes done");
    dev_wr(REG_CTRL_STAT, 8'h40);
    tick(8);
    cmp_pin(4'(laser_on), 4'h0);
    dev_rd(REG_CTRL_STAT, 8'h40, 8'h40, 1'b0);
    dev_wr(REG_CTRL_STAT, 8'h00);
    tick(8);
    cmp_pin(4'(laser_on), 4'h1);
    $display("test soft off done");
    apb(1, APB_CTRL, 32'h0000_0001, 0, 0, 0, s);
    tick(8);
    cmp_pin(4'(laser_on), 4'h0);
    apb(0, APB_CTRL, 0, 32'h0000_0001, 32'h0000_0001, 0, s);
    apb(0, APB_STAT, 0, 32'h0000_0010, 32'h0000_0010, 0, s);
    dev_rd(REG_CTRL_STAT, 8'h80, 8'h80, 1'b0);
    apb(1, APB_CTRL, 32'h0000_0000, 0, 0, 0, s);
    tick(8);
    cmp_pin(4'(laser_on), 4'h1);
    $display("test pin off done");
    for (int i = 0; i < 6; i++) begin
      optical_signal_in <= 1'($random(seed));
      tick(8);
      cmp_pin(4'(link.rx_los), {3'h0, ~optical_signal_in});
    end
    optical_signal_in <= 1'b0;
    tick(8);
    apb(0, APB_STAT, 0, 32'h0000_0008, 32'h0000_0008, 0, s);
    dev_rd(REG_CTRL_STAT, 8'h02, 8'h02, 1'b0);
    optical_signal_in <= 1'b1;
    tick(8);
    dev_rd(REG_CTRL_STAT, 8'h02, 8'h00, 1'b0);
    $display("test signal loss done");
    laser_fault_in <= 1'b1;
    tick(8);
    laser_fault_in <= 1'b0;
    tick(8);
    cmp_pin(4'(link.tx_fault), 4'h1);
    cmp_pin(4'(laser_on), 4'h0);
    dev_rd(REG_CTRL_STAT, 8'h04, 8'h04, 1'b0);
    apb(1, APB_CTRL, 32'h0000_0001, 0, 0, 0, s);
    tick(100);
    apb(1, APB_CTRL, 32'h0000_0000, 0, 0, 0, s);
    tick(8);
    cmp_pin(4'(link.tx_fault), 4'h1);
    apb(1, APB_CTRL, 32'h0000_0002, 0, 0, 0, s);
    tick(RESET_CYC + 20);
    cmp_pin(4'(link.tx_fault), 4'h0);
    cmp_pin(4'(laser_on), 4'h1);
    $display("test fault done");
    tally_and_finish();
  end
endmodule
